// file: logic/rx_hdlc_disassembly_policer.sv
module rx_hdlc_disassembly_policer #(
    parameter int FB_AW = 12
) (
    input wire logic ref_clk,                       // Core clock
    input wire logic nrst,                          // Async reset, active low
    input wire logic pkt_start,                     // Packet header pulse
    input wire rx_hdlc_pkg::pkt_info_t pkt_info,    // Seq, timestamp, length
    input wire rx_hdlc_pkg::chan_cfg_t pkt_cfg,     // Channel structure
    input wire logic [31:0] frame_time,             // Local time in frames
    input wire logic [7:0] pkt_data,                // Payload byte
    input wire logic pkt_valid,                     // Payload byte valid
    output logic pkt_ready,                         // Payload byte taken
    output logic mem_valid,                         // Memory request
    output rx_hdlc_pkg::mem_cmd_t mem_cmd,          // Memory command
    input wire logic mem_ack,                       // Memory request done
    input wire rx_hdlc_pkg::buf_ctl_t mem_rdata,    // Buffer record read
    output logic busy,                              // Packet in progress
    output logic wb_valid,                          // Channel state write
    output rx_hdlc_pkg::chan_state_t wb_state,      // Updated channel state
    output logic ev_valid,                          // Event report pulse
    output rx_hdlc_pkg::event_t ev,                 // Event report
    output logic rec_a_valid,                       // Recovery queue A post
    output logic rec_b_valid,                       // Recovery queue B post
    output rx_hdlc_pkg::recov_t rec_evt             // Recovery event
);
    import rx_hdlc_pkg::*;

    typedef enum logic [3:0] {S_IDLE, S_POLICE, S_OPEN, S_HDR, S_BODY, S_CRC, S_CLOSE,
        S_PAD, S_FETCH, S_CHECK, S_COPY, S_DESC, S_WBACK, S_DROP, S_DONE} state_t;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < BITS_PER_BYTE; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    state_t st_reg;
    pkt_info_t info_reg;
    chan_cfg_t cfg_reg;
    buf_ctl_t ctl_reg;
    logic [7:0] frame_mem [2**FB_AW];
    logic [FB_AW:0] fb_len_reg;
    logic [FB_AW:0] cp_idx_reg;
    logic [1:0] idx_reg;
    logic [15:0] left_reg;
    logic [15:0] crc_reg;
    logic fr_busy_reg, fr_raw_reg;
    logic [7:0] fr_byte_reg;
    logic [3:0] fr_bits_reg;
    logic [2:0] ones_reg;
    logic [7:0] pk_sh_reg;
    logic [2:0] pk_n_reg;
    logic police_err_reg, no_room_reg;
    logic pkt_ready_reg, mem_valid_reg, busy_reg, wb_valid_reg;
    logic ev_valid_reg, rec_a_reg, rec_b_reg;
    mem_cmd_t mem_cmd_reg;
    chan_state_t wb_state_reg;
    event_t ev_reg;
    recov_t rec_reg;

    // Policing arithmetic
    wire [20:0] rate_ones = 21'({1'b1, cfg_reg.rate_mant}) << cfg_reg.rate_exp;
    wire [20:0] drain_rate = 21'((rate_ones * RATE_BASE_UNITS) >> RATE_MANT_SH);
    wire [31:0] elapsed = frame_time - cfg_reg.st.last_ts;
    wire [52:0] drain_amt = cfg_reg.st.init ? 53'(elapsed) * 53'(drain_rate) : 53'h0;
    wire [22:0] lvl = cfg_reg.st.bucket_level;
    wire [22:0] lvl_dis = (drain_amt >= 53'(lvl)) ? 23'h0 : lvl - 23'(drain_amt);
    wire [23:0] pkt_units = 24'({info_reg.len, 6'h00});
    wire [23:0] lvl_sum = 24'(lvl_dis) + pkt_units;
    wire [16:0] max_bytes = (cfg_reg.max_fill == 16'h0) ? MAX_FILL_ZERO
                                                        : {1'b0, cfg_reg.max_fill};
    wire [23:0] max_units = 24'(max_bytes) << FILL_SH;
    wire police_ok = !(lvl_sum > max_units);
    wire [22:0] lvl_new = police_ok ? 23'(lvl_sum) : lvl_dis;

    // Header layout decode
    wire [2:0] hs = cfg_reg.hdr_sel;
    wire [1:0] n_addr = (hs == HDR_A1 || hs == HDR_A1C) ? 2'h1
                      : (hs == HDR_A2 || hs == HDR_A2C) ? 2'h2 : 2'h0;
    wire has_ctrl = (hs == HDR_A1C || hs == HDR_A2C);
    wire [1:0] hdr_total = n_addr + {1'b0, has_ctrl};
    wire [7:0] hdr_byte = (idx_reg == n_addr) ? cfg_reg.ctrl
                        : (n_addr == 2'h2 && idx_reg == 2'h0) ? cfg_reg.addr[15:8]
                        : cfg_reg.addr[7:0];
    wire state_t after_body = cfg_reg.crc_en ? S_CRC : S_CLOSE;
    wire state_t after_hdr = (info_reg.len != 16'h0) ? S_BODY : after_body;
    wire state_t after_open = (hdr_total != 2'h0) ? S_HDR : after_hdr;

    // Byte source feeding the framer
    wire body_take = pkt_valid && pkt_ready_reg;
    wire src_st = (st_reg == S_OPEN || st_reg == S_HDR || st_reg == S_CRC
                   || st_reg == S_CLOSE);
    wire ld = (src_st && !fr_busy_reg) || (st_reg == S_BODY && body_take);
    wire ld_raw = (st_reg == S_OPEN || st_reg == S_CLOSE);
    wire [7:0] crc_out = (idx_reg == 2'h0) ? ~crc_reg[7:0] : ~crc_reg[15:8];
    wire [7:0] ld_byte = ld_raw ? FLAG_BYTE
                       : (st_reg == S_HDR) ? hdr_byte
                       : (st_reg == S_BODY) ? pkt_data : crc_out;
    wire crc_upd = ld && (st_reg == S_HDR || st_reg == S_BODY);
    wire drop_take = (st_reg == S_DROP) && body_take;

    // Framer datapath
    // style select
    wire bitwise = !cfg_reg.framing_style_select;
    // zero insertion after five ones
    // Raw flag bits clear the run, so a run of five before a flag still gets its zero
    wire stuff = bitwise && ones_reg == ONES_MAX;
    wire bit_v = stuff ? 1'b0 : fr_byte_reg[0];
    wire esc = !fr_raw_reg && (fr_byte_reg == FLAG_BYTE || fr_byte_reg == ESC_BYTE);
    wire bw_wr = fr_busy_reg && !bitwise;
    wire pad_push = (st_reg == S_PAD) && !fr_busy_reg && pk_n_reg != 3'h0;
    wire pb_en = (fr_busy_reg && bitwise) || pad_push;
    wire pb = pad_push ? 1'b1 : bit_v;
    wire fb_we = bw_wr || (pb_en && pk_n_reg == PACK_LAST);
    wire [7:0] fb_wd = !bw_wr ? {pb, pk_sh_reg[7:1]} : (esc ? ESC_BYTE : fr_byte_reg);
    wire frame_done = (st_reg == S_PAD) && !fr_busy_reg && pk_n_reg == 3'h0;
    wire new_pkt = (st_reg == S_POLICE) && police_ok;

    // Ring space
    wire [15:0] used = ctl_reg.wr_ptr - ctl_reg.rd_ptr;
    wire [15:0] free_sp = ~used;
    wire fits = !fb_len_reg[FB_AW] && (16'(fb_len_reg) <= free_sp);
    wire [15:0] cp_ptr = ctl_reg.wr_ptr + 16'(cp_idx_reg);
    wire mem_done = mem_valid_reg && mem_ack;
    wire last_cp = (cp_idx_reg + 1'b1) == fb_len_reg;
    wire rdy_next = (st_reg == S_BODY && !fr_busy_reg && !body_take)
                 || (st_reg == S_DROP && !(drop_take && left_reg == 16'h1));

    // Frame store, no reset needed
    always_ff @(posedge ref_clk) begin
        if (fb_we && !fb_len_reg[FB_AW]) begin
            frame_mem[fb_len_reg[FB_AW-1:0]] <= fb_wd;
        end
    end

    // Framer shift and escape engine
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fr_busy_reg <= 1'b0;
            fr_raw_reg <= 1'b0;
            fr_byte_reg <= 8'h00;
            fr_bits_reg <= 4'h0;
            ones_reg <= 3'h0;
        end else if (new_pkt) begin
            fr_busy_reg <= 1'b0;
            ones_reg <= 3'h0;
        end else if (ld) begin
            fr_busy_reg <= 1'b1;
            fr_byte_reg <= ld_byte;
            fr_raw_reg <= ld_raw;
            fr_bits_reg <= BYTE_BITS;
        end else if (fr_busy_reg && bitwise) begin
            if (stuff) begin
                ones_reg <= 3'h0;
            end else begin
                fr_byte_reg <= fr_byte_reg >> 1;
                ones_reg <= (fr_raw_reg || !bit_v) ? 3'h0 : ones_reg + 3'h1;
                fr_bits_reg <= fr_bits_reg - 4'h1;
                fr_busy_reg <= fr_bits_reg != 4'h1;
            end
        end else if (fr_busy_reg) begin
            // escape applies to header and CRC too
            if (esc) begin
                fr_byte_reg <= fr_byte_reg ^ ESC_XOR;
            end else begin
                fr_busy_reg <= 1'b0;
            end
        end
    end

    // Bit packer and frame length
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pk_sh_reg <= 8'h00;
            pk_n_reg <= 3'h0;
            fb_len_reg <= '0;
        end else if (new_pkt) begin
            pk_n_reg <= 3'h0;
            fb_len_reg <= '0;
        end else begin
            if (pb_en) begin
                pk_sh_reg <= {pb, pk_sh_reg[7:1]};
                pk_n_reg <= pk_n_reg + 3'h1;
            end
            if (fb_we && !fb_len_reg[FB_AW]) begin
                fb_len_reg <= fb_len_reg + 1'b1;
            end
        end
    end

    // Packet sequencing
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= S_IDLE;
            info_reg <= '0;
            cfg_reg <= '0;
            ctl_reg <= '0;
            idx_reg <= 2'h0;
            left_reg <= 16'h0;
            crc_reg <= CRC_INIT;
            cp_idx_reg <= '0;
            police_err_reg <= 1'b0;
            no_room_reg <= 1'b0;
        end else begin
            if (crc_upd) begin
                crc_reg <= crc_byte(crc_reg, ld_byte);
            end
            if (drop_take || (st_reg == S_BODY && ld)) begin
                left_reg <= left_reg - 16'h1;
            end
            case (st_reg)
                S_IDLE: begin
                    if (pkt_start) begin
                        info_reg <= pkt_info;
                        cfg_reg <= pkt_cfg;
                        police_err_reg <= 1'b0;
                        no_room_reg <= 1'b0;
                        st_reg <= S_POLICE;
                    end
                end
                S_POLICE: begin
                    left_reg <= info_reg.len;
                    idx_reg <= 2'h0;
                    crc_reg <= CRC_INIT;
                    cp_idx_reg <= '0;
                    if (police_ok) begin
                        st_reg <= S_OPEN;
                    end else begin
                        police_err_reg <= 1'b1;
                        st_reg <= (info_reg.len != 16'h0) ? S_DROP : S_DONE;
                    end
                end
                S_OPEN: if (ld) st_reg <= after_open;
                S_HDR: begin
                    if (ld) begin
                        idx_reg <= (idx_reg == hdr_total - 2'h1) ? 2'h0 : idx_reg + 2'h1;
                        if (idx_reg == hdr_total - 2'h1) st_reg <= after_hdr;
                    end
                end
                S_BODY: if (ld && left_reg == 16'h1) st_reg <= after_body;
                S_CRC: begin
                    if (ld) begin
                        idx_reg <= idx_reg + 2'h1;
                        if (idx_reg == 2'h1) st_reg <= S_CLOSE;
                    end
                end
                S_CLOSE: if (ld) st_reg <= S_PAD;
                S_PAD: if (frame_done) st_reg <= S_FETCH;
                S_FETCH: begin
                    if (mem_done) begin
                        ctl_reg <= mem_rdata;
                        st_reg <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (fits) begin
                        st_reg <= S_COPY;
                    end else begin
                        no_room_reg <= 1'b1;
                        st_reg <= S_DONE;
                    end
                end
                S_COPY: begin
                    if (mem_done) begin
                        cp_idx_reg <= cp_idx_reg + 1'b1;
                        if (last_cp) st_reg <= S_DESC;
                    end
                end
                S_DESC: if (mem_done) st_reg <= S_WBACK;
                S_WBACK: if (mem_done) st_reg <= S_DONE;
                S_DROP: if (drop_take && left_reg == 16'h1) st_reg <= S_DONE;
                S_DONE: st_reg <= S_IDLE;
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    // Memory commands per state
    wire issue = !mem_valid_reg && (st_reg == S_FETCH || st_reg == S_COPY
                 || st_reg == S_DESC || st_reg == S_WBACK);
    wire [23:0] stream_addr = 24'(cfg_reg.stream);
    mem_cmd_t cmd_next;
    always_comb begin
        cmd_next = mem_cmd_reg;
        case (st_reg)
            S_FETCH: cmd_next = '{MEM_CTL_RD, stream_addr, 32'h0};
            S_COPY: cmd_next = '{MEM_BUF_WR, ctl_reg.base + 24'(cp_ptr),
                                 {24'h0, frame_mem[cp_idx_reg[FB_AW-1:0]]}};
            S_DESC: cmd_next = '{MEM_DESC_WR, stream_addr,
                                 {ctl_reg.wr_ptr, 16'(fb_len_reg)}};
            S_WBACK: cmd_next = '{MEM_PTR_WR, stream_addr,
                                  {16'h0, ctl_reg.wr_ptr + 16'(fb_len_reg)}};
            default: cmd_next = mem_cmd_reg;
        endcase
    end

    // Memory handshake and ready
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem_valid_reg <= 1'b0;
            mem_cmd_reg <= '0;
            pkt_ready_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            pkt_ready_reg <= rdy_next;
            busy_reg <= (st_reg != S_IDLE) || pkt_start;
            if (issue) begin
                mem_valid_reg <= 1'b1;
                mem_cmd_reg <= cmd_next;
            end else if (mem_done) begin
                mem_valid_reg <= 1'b0;
            end
        end
    end

    // Channel state, recovery and event reports
    wire in_police = (st_reg == S_POLICE);
    wire ev_fire = (st_reg == S_DONE)
                && (cfg_reg.report_every_packet || police_err_reg || no_room_reg);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wb_valid_reg <= 1'b0;
            wb_state_reg <= '0;
            ev_valid_reg <= 1'b0;
            ev_reg <= '0;
            rec_a_reg <= 1'b0;
            rec_b_reg <= 1'b0;
            rec_reg <= '0;
        end else begin
            wb_valid_reg <= in_police;
            rec_a_reg <= in_police && cfg_reg.rec_a;
            rec_b_reg <= in_police && cfg_reg.rec_b;
            ev_valid_reg <= ev_fire;
            if (in_police) begin
                rec_reg <= '{info_reg.seq, info_reg.ts};
                wb_state_reg <= '{lvl_new, frame_time, 1'b1,
                                  cfg_reg.st.pkt_cnt + 16'h1,
                                  cfg_reg.st.oct_cnt + 32'(info_reg.len)};
            end
            if (ev_fire) begin
                ev_reg <= '{cfg_reg.stream, police_err_reg, no_room_reg, info_reg.seq};
            end
        end
    end

    assign pkt_ready = pkt_ready_reg;
    assign mem_valid = mem_valid_reg;
    assign mem_cmd = mem_cmd_reg;
    assign busy = busy_reg;
    assign wb_valid = wb_valid_reg;
    assign wb_state = wb_state_reg;
    assign ev_valid = ev_valid_reg;
    assign ev = ev_reg;
    assign rec_a_valid = rec_a_reg;
    assign rec_b_valid = rec_b_reg;
    assign rec_evt = rec_reg;
endmodule // rx_hdlc_disassembly_policer

// file: logic/rx_hdlc_pkg.sv
package rx_hdlc_pkg;
    // HDLC streams and framing bytes
    localparam int STREAM_W = 9;
    localparam int STREAM_COUNT = 512;
    localparam logic [7:0] FLAG_BYTE = 8'h7e;
    localparam logic [7:0] ESC_BYTE = 8'h7d;
    localparam logic [7:0] ESC_XOR = 8'h20;
    localparam logic [2:0] ONES_MAX = 3'h5;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] PACK_LAST = 3'h7;
    // CRC-16 (CCITT, reflected)
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    // Header selection codes
    localparam logic [2:0] HDR_NONE = 3'h0;
    localparam logic [2:0] HDR_A1 = 3'h1;
    localparam logic [2:0] HDR_A2 = 3'h2;
    localparam logic [2:0] HDR_A1C = 3'h3;
    localparam logic [2:0] HDR_A2C = 3'h4;
    // Bucket units and drain rate
    localparam int FILL_SH = 6;
    localparam int FILL_UNITS_PER_BYTE = 64;
    localparam int BITS_PER_BYTE = 8;
    localparam int RATE_BASE_BPS = 4000;
    localparam int FRAME_HZ = 8000;
    localparam int RATE_BASE_UNITS =
        RATE_BASE_BPS * FILL_UNITS_PER_BYTE / (BITS_PER_BYTE * FRAME_HZ);
    localparam int RATE_MANT_SH = 3;
    localparam logic [16:0] MAX_FILL_ZERO = 17'h10000;

    typedef enum logic [1:0] {MEM_CTL_RD, MEM_BUF_WR, MEM_DESC_WR, MEM_PTR_WR} mem_kind_t;
    typedef struct packed {
        mem_kind_t kind;
        logic [23:0] addr;
        logic [31:0] data;
    } mem_cmd_t;
    typedef struct packed {
        logic [23:0] base;
        logic [15:0] rd_ptr;
        logic [15:0] wr_ptr;
    } buf_ctl_t;
    typedef struct packed {
        logic [15:0] seq;
        logic [31:0] ts;
        logic [15:0] len;
    } pkt_info_t;
    typedef struct packed {
        logic [22:0] bucket_level;
        logic [31:0] last_ts;
        logic init;
        logic [15:0] pkt_cnt;
        logic [31:0] oct_cnt;
    } chan_state_t;
    typedef struct packed {
        logic rec_a;
        logic rec_b;
        logic framing_style_select;
        logic report_every_packet;
        logic [STREAM_W-1:0] stream;
        logic [2:0] hdr_sel;
        logic crc_en;
        logic [15:0] addr;
        logic [7:0] ctrl;
        logic [1:0] rate_mant;
        logic [3:0] rate_exp;
        logic [15:0] max_fill;
        chan_state_t st;
    } chan_cfg_t;
    typedef struct packed {
        logic [STREAM_W-1:0] stream;
        logic police_err;
        logic no_room;
        logic [15:0] seq;
    } event_t;
    typedef struct packed {
        logic [15:0] seq;
        logic [31:0] ts;
    } recov_t;
endpackage

// file: testbench/egress_mem_model.sv
module egress_mem_model (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic [1:0] slow, // Ack wait cycles
    input wire logic mem_valid, // Request
    input wire rx_hdlc_pkg::mem_cmd_t mem_cmd, // Command
    output logic mem_ack, // Done
    output rx_hdlc_pkg::buf_ctl_t mem_rdata // Record
);
    import rx_hdlc_pkg::*;
    buf_ctl_t rec;
    logic [7:0] bytes[$];
    logic [31:0] desc;
    logic [1:0] w;
    assign mem_rdata = (mem_ack && mem_cmd.kind == MEM_CTL_RD) ? rec : ~rec;
    // Ack after slow wait cycles
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem_ack <= 1'b0;
            w <= 2'h0;
        end else begin
            mem_ack <= mem_valid && !mem_ack && w == slow;
            w <= (mem_valid && !mem_ack && w != slow) ? w + 2'h1 : 2'h0;
        end
    end
    always @(posedge ref_clk) begin
        if (mem_valid && mem_ack) begin
            case (mem_cmd.kind)
                MEM_BUF_WR: bytes.push_back(mem_cmd.data[7:0]);
                MEM_DESC_WR: desc = mem_cmd.data;
                MEM_PTR_WR: rec.wr_ptr = mem_cmd.data[15:0];
                default: ;
            endcase
        end
    end
endmodule // egress_mem_model

// file: testbench/rx_hdlc_checker.sv
module rx_hdlc_checker (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic pkt_start, // Start
    input wire rx_hdlc_pkg::pkt_info_t pkt_info, // Info
    input wire rx_hdlc_pkg::chan_cfg_t pkt_cfg, // Config
    input wire logic [31:0] frame_time, // Time
    input wire logic busy, // Busy
    input wire logic wb_valid, // Write back
    input wire rx_hdlc_pkg::chan_state_t wb_state, // State
    input wire logic rec_a_valid, // Queue A
    input wire logic rec_b_valid, // Queue B
    input wire rx_hdlc_pkg::recov_t rec_evt, // Recovery
    input wire logic mem_valid, // Request
    input wire rx_hdlc_pkg::mem_cmd_t mem_cmd, // Command
    input wire logic mem_ack, // Done
    input wire logic ev_valid, // Event
    input wire rx_hdlc_pkg::event_t ev // Event data
);
    import rx_hdlc_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Packet taken
    wire take = pkt_start && !busy;
    // Per packet results
    a_wb_pulse: assert property (take |-> ##2 wb_valid)
        else $error("state write missing");
    a_pkt_count: assert property (take |-> ##2
        wb_state.pkt_cnt == $past(pkt_cfg.st.pkt_cnt, 2) + 16'h1) else $error("packet count");
    a_oct_count: assert property (take |-> ##2 wb_state.oct_cnt ==
        $past(pkt_cfg.st.oct_cnt, 2) + {16'h0, $past(pkt_info.len, 2)}) else $error("octet count");
    a_queue_a: assert property (take |-> ##2 rec_a_valid == $past(pkt_cfg.rec_a, 2)
        && rec_evt.seq == $past(pkt_info.seq, 2)) else $error("queue A post");
    a_queue_b: assert property (take |-> ##2 rec_b_valid == $past(pkt_cfg.rec_b, 2)
        && rec_evt.ts == $past(pkt_info.ts, 2)) else $error("queue B post");
    a_stamp_kept: assert property (wb_valid |-> wb_state.init
        && wb_state.last_ts == $past(frame_time)) else $error("stamp not kept");
    // Memory side ordering
    a_ptr_after: assert property (mem_valid && mem_ack && mem_cmd.kind == MEM_DESC_WR
        |=> ##[0:3] mem_valid && mem_cmd.kind == MEM_PTR_WR) else $error("no pointer write");
    a_req_hold: assert property (mem_valid && !mem_ack |=> mem_valid && $stable(mem_cmd))
        else $error("request dropped");
    c_police: cover property (ev_valid && ev.police_err);
    c_noroom: cover property (ev_valid && ev.no_room);
    c_ptr: cover property (mem_valid && mem_ack && mem_cmd.kind == MEM_PTR_WR);
endmodule // rx_hdlc_checker

bind rx_hdlc_disassembly_policer rx_hdlc_checker chk_i (.ref_clk, .nrst, .pkt_start, .pkt_info,
    .pkt_cfg, .frame_time, .busy, .wb_valid, .wb_state, .rec_a_valid, .rec_b_valid, .rec_evt,
    .mem_valid, .mem_cmd, .mem_ack, .ev_valid, .ev);

// file: testbench/tb_rx_hdlc_disassembly_policer.sv
module tb_rx_hdlc_disassembly_policer import rx_hdlc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, nrst = 0, pkt_start = 0, pkt_valid = 0, ev_seen = 0;
    logic [7:0] pkt_data = 8'h0;
    logic [31:0] frame_time = 32'h0;
    logic [1:0] slow = 2'h0;
    pkt_info_t pkt_info = '0;
    chan_cfg_t pkt_cfg = '0, b0, c;
    logic pkt_ready, mem_valid, mem_ack, busy, wb_valid, ev_valid, rec_a_valid, rec_b_valid;
    mem_cmd_t mem_cmd;
    buf_ctl_t mem_rdata;
    chan_state_t wb_state, wb_got;
    event_t ev, ev_got;
    recov_t rec_evt;
    int err_total = 0, n_compared = 0, cyc = 0;
    logic [7:0] q[$], x[$], y[$];
    logic [15:0] crc;
    rx_hdlc_disassembly_policer rx_hdlc_disassembly_policer_i (.ref_clk, .nrst, .pkt_start,
        .pkt_info, .pkt_cfg, .frame_time, .pkt_data, .pkt_valid, .pkt_ready, .mem_valid, .mem_cmd,
        .mem_ack, .mem_rdata, .busy, .wb_valid, .wb_state, .ev_valid, .ev, .rec_a_valid,
        .rec_b_valid, .rec_evt);
    egress_mem_model egress_mem_model_i (.ref_clk, .nrst, .slow, .mem_valid, .mem_cmd, .mem_ack,
        .mem_rdata);
    initial forever #2 ref_clk = ~ref_clk;
    // Capture pulses, cut hangs
    always @(posedge ref_clk) begin
        cyc++;
        if (wb_valid) wb_got <= wb_state;
        if (ev_valid) begin
            ev_seen <= 1'b1;
            ev_got <= ev;
        end
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One packet with payload q, until idle again
    task automatic send(input logic [31:0] t);
        int i, k;
        i = 0;
        ev_seen = 1'b0;
        egress_mem_model_i.bytes.delete();
        @(posedge ref_clk);
        pkt_start <= 1'b1;
        pkt_cfg <= c;
        frame_time <= t;
        pkt_info <= '{16'h1234 + 16'(cyc), 32'(cyc) ^ 32'h5a5a0000, 16'(q.size())};
        pkt_valid <= q.size() > 0;
        pkt_data <= q.size() > 0 ? q[0] : 8'h0;
        @(posedge ref_clk);
        pkt_start <= 1'b0;
        for (k = 0; k < 9000 && (k < 3 || busy); k++) begin
            @(posedge ref_clk);
            if (pkt_valid && pkt_ready) begin
                i++;
                pkt_valid <= i < q.size();
                pkt_data <= i < q.size() ? q[i] : ~pkt_data;
            end
        end
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic chk_frame(input string m);
        chk(32'(egress_mem_model_i.bytes.size()), 32'(y.size()), m);
        foreach (y[i]) chk({24'h0, egress_mem_model_i.bytes[i]}, {24'h0, y[i]}, m);
    endtask
    task automatic t_bytewise();
        c = b0;
        c.hdr_sel = HDR_A2C;
        c.crc_en = 1'b1;
        c.addr = 16'h7d12;
        c.ctrl = 8'h03;
        c.rec_a = 1'b1;
        q = '{8'h7e, 8'h41};
        x = '{8'h7d, 8'h12, 8'h03, 8'h7e, 8'h41};
        crc = 16'hffff;
        foreach (x[i]) begin
            crc ^= {8'h0, x[i]};
            repeat (8) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
        end
        x.push_back(~crc[7:0]);
        x.push_back(~crc[15:8]);
        y = '{8'h7e};
        foreach (x[i]) begin
            if (x[i] == 8'h7e || x[i] == 8'h7d) y.push_back(8'h7d);
            y.push_back((x[i] == 8'h7e || x[i] == 8'h7d) ? x[i] ^ 8'h20 : x[i]);
        end
        y.push_back(8'h7e);
        egress_mem_model_i.rec = '{24'h100, 16'hfffe, 16'hfffe};
        send(32'h5);
        chk_frame("byte-wise frame");
        chk(egress_mem_model_i.desc, {16'hfffe, 16'(y.size())}, "descriptor");
        chk(32'(egress_mem_model_i.rec.wr_ptr), 32'(16'(16'hfffe + y.size())), "wr ptr");
        chk(32'(ev_got.stream), 32'(c.stream), "event stream");
        $display("done byte-wise");
    endtask
    task automatic t_headers();
        slow <= 2'h2;
        for (int h = 0; h < 6; h++) begin
            c = b0;
            c.hdr_sel = 3'(h);
            c.addr = 16'h2233;
            c.ctrl = 8'h44;
            q = {};
            y = '{8'h7e};
            if (h == 1 || h == 3) y.push_back(8'h33);
            if (h == 2 || h == 4) y = '{8'h7e, 8'h22, 8'h33};
            if (h == 3 || h == 4) y.push_back(8'h44);
            y.push_back(8'h7e);
            send(32'h6);
            chk_frame("header code");
        end
        slow <= 2'h0;
        $display("done headers");
    endtask
    task automatic t_bitwise();
        c = b0;
        c.framing_style_select = 1'b0;
        c.rec_b = 1'b1;
        q = '{8'hff, 8'hff};
        y = '{8'h7e, 8'hdf, 8'hf7, 8'hf5, 8'hfb};
        send(32'h7);
        chk_frame("bit-wise frame");
        $display("done bit-wise");
    endtask
    task automatic pol(input logic [31:0] t, input logic [31:0] lvl, input logic err);
        send(t);
        chk(32'(wb_got.bucket_level), lvl, "bucket level");
        chk(32'(ev_got.police_err), 32'(err), "police flag");
    endtask
    task automatic t_police();
        c = b0;
        c.max_fill = 16'h1;
        q = '{8'haa, 8'hbb};
        pol(32'h9, 32'h0, 1'b1);
        chk(32'(egress_mem_model_i.bytes.size()), 32'h0, "dropped frame written");
        q = '{8'haa};
        pol(32'h9, 32'h40, 1'b0);
        c.max_fill = 16'h0;
        c.st.init = 1'b1;
        c.st.bucket_level = 23'h280;
        pol(32'h5, 32'h2ac, 1'b0);
        q = {};
        pol(32'h1000, 32'h0, 1'b0);
        $display("done policing");
    endtask
    task automatic t_noroom();
        c = b0;
        q = '{8'h01, 8'h02};
        egress_mem_model_i.rec = '{24'h100, 16'h0010, 16'h000f};
        send(32'h8);
        chk(32'(egress_mem_model_i.bytes.size()), 32'h0, "partial frame");
        chk(32'(egress_mem_model_i.rec.wr_ptr), 32'hf, "pointer moved");
        chk({ev_seen, ev_got.no_room}, 32'h3, "no room event");
        $display("done no room");
    endtask
    // Main sequence
    initial begin
        b0 = '0;
        b0.framing_style_select = 1'b1;
        b0.report_every_packet = 1'b1;
        b0.stream = 9'h1a5;
        b0.rate_exp = 4'h1;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        t_bytewise();
        t_headers();
        t_bitwise();
        t_police();
        t_noroom();
        final_report();
    end
endmodule // tb_rx_hdlc_disassembly_policer
